// >>> ncmpp_pkg.sv
package ncmpp_pkg;

  localparam int AXI_AW = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COL = 8'h04;
  localparam logic [7:0] REG_ROW = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_WPCTL = 8'h14;

  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SECOND_BIT = 3;
  localparam int CTRL_CFM_LSB = 4;
  localparam int CTRL_EXT_BIT = 6;
  localparam logic [2:0] OP_SETUP = 3'h1;
  localparam logic [2:0] OP_CONFIRM = 3'h2;
  localparam logic [2:0] OP_STATUS = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h4;
  localparam logic [1:0] CFM_11 = 2'h0;
  localparam logic [1:0] CFM_15 = 2'h1;
  localparam logic [1:0] CFM_10 = 2'h2;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_RB_BIT = 2;
  localparam int STAT_CACHED_BIT = 3;
  localparam int STAT_MULTI_BIT = 4;
  localparam int STAT_BYTE_LSB = 8;
  localparam int STAT_PAGES_LSB = 16;

  // Device commands
  localparam logic [7:0] CMD_SETUP1 = 8'h80;
  localparam logic [7:0] CMD_SETUP2 = 8'h81;
  localparam logic [7:0] CMD_DIST1 = 8'h11;
  localparam logic [7:0] CMD_CACHE = 8'h15;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_STAT = 8'h70;
  localparam logic [7:0] CMD_STAT_EXT = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // Address layout
  localparam int ADDR_CYCLES = 5;
  localparam int COL_W = 13;
  localparam int ROW_W = 18;
  localparam int PAGE_W = 6;
  localparam logic [5:0] LAST_PAGE = 6'h3f;
  localparam int HALF_BIT = 11;

  // Pin timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SETUP_NS = 25;
  localparam int T_PULSE_NS = 25;
  localparam int T_HOLD_NS = 25;
  localparam int T_WB_NS = 100;
  localparam int T_SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} ncmpp_kind_t;

endpackage

// >>> ncmpp_axil.sv
`timescale 1ns/1ps
module ncmpp_axil
  import ncmpp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [AXI_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [AXI_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic bvalid;
    logic arready;
    logic ar_pend;
    logic rvalid;
    logic [31:0] rdata;
    logic wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [AXI_AW-1:0] rd_addr;
  } ncmpp_axil_t;

  ncmpp_axil_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.wr_en = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      // A write without all four strobes still goes through, with zero in place of the data
      next_s.wr_data = (s_axi_wstrb == 4'hf) ? s_axi_wdata : 32'h0000_0000;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.wr_en = 1'b1;
      next_s.bvalid = 1'b1;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    if (s_axi_arvalid && s.arready) begin
      next_s.rd_addr = s_axi_araddr;
      next_s.ar_pend = 1'b1;
    end
    if (s.ar_pend) begin
      next_s.ar_pend = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.ar_pend && !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = 2'h0;
  assign wr_en = s.wr_en;
  assign wr_addr = s.wr_addr;
  assign wr_data = s.wr_data;
  assign rd_addr = s.rd_addr;

endmodule

// >>> ncmpp_pin_cycle.sv
`timescale 1ns/1ps
module ncmpp_pin_cycle
  import ncmpp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire ncmpp_kind_t kind,
  input wire logic [7:0] byte_out,
  input wire logic [7:0] io_in,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic [7:0] byte_in,
  output logic done
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} ncmpp_ph_t;

  typedef struct packed {
    ncmpp_ph_t ph;
    logic [3:0] cnt;
    logic rd;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io_out;
    logic io_oe;
    logic [7:0] byte_in;
    logic done;
  } ncmpp_pc_t;

  ncmpp_pc_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.ph)
      E_IDLE: begin
        if (start) begin
          next_s.ph = E_SETUP;
          next_s.cnt = 4'(T_SETUP_CYC - 1);
          next_s.rd = (kind == K_RD);
          next_s.cle = (kind == K_CMD);
          next_s.ale = (kind == K_ADDR);
          next_s.io_out = byte_out;
          next_s.io_oe = (kind != K_RD);
        end
      end
      E_SETUP: begin
        if (s.cnt == 4'h0) begin
          next_s.ph = E_PULSE;
          next_s.cnt = 4'(T_PULSE_CYC - 1);
          next_s.we_n = s.rd;
          next_s.re_n = !s.rd;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      E_PULSE: begin
        if (s.cnt == 4'h0) begin
          next_s.ph = E_HOLD;
          next_s.cnt = 4'(T_HOLD_CYC - 1);
          next_s.we_n = 1'b1;
          next_s.re_n = 1'b1;
          if (s.rd) begin
            next_s.byte_in = io_in;
          end
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      E_HOLD: begin
        if (s.cnt == 4'h0) begin
          next_s.ph = E_IDLE;
          next_s.cle = 1'b0;
          next_s.ale = 1'b0;
          next_s.io_oe = 1'b0;
          next_s.done = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      default: next_s.ph = E_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cle = s.cle;
  assign ale = s.ale;
  assign we_n = s.we_n;
  assign re_n = s.re_n;
  assign io_out = s.io_out;
  assign io_oe = s.io_oe;
  assign byte_in = s.byte_in;
  assign done = s.done;

endmodule

// >>> ncmpp_host.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Sequence ends with 10h; wait ready
// - Block change forces sequence restart
// - 64 incrementing pages, finish 81h-10h
// - Paired blocks stay in one half
// - One block per district, same page
// - Only 70h or reset between 11h/81h; code also takes 71h there
// - Started sequence takes only sequence commands
module ncmpp_host
  import ncmpp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic ready_busy_output
);

  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_ADDR, S_DATA, S_WB, S_WAIT_RB, S_STAT_RD
  } ncmpp_st_t;

  typedef enum logic [1:0] {P_NONE, P_ADDR1, P_WAIT2, P_ADDR2} ncmpp_ph_t;

  typedef struct packed {
    ncmpp_st_t st;
    ncmpp_ph_t ph;
    logic cached;
    logic multi;
    logic [7:0] cmd;
    logic [2:0] aidx;
    logic [3:0] wb_cnt;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [11:0] first_blk;
    logic [PAGE_W-1:0] first_pg;
    logic [11:0] seq_blk;
    logic [PAGE_W-1:0] seq_pg;
    logic [6:0] pages;
    logic [7:0] stat_byte;
    logic [7:0] data_rd;
    logic err;
    logic ce_n;
    logic wp_n;
    logic eng_start;
    ncmpp_kind_t eng_kind;
    logic [7:0] eng_byte;
  } ncmpp_host_t;

  ncmpp_host_t s, next_s;

  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [AXI_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic eng_done;
  logic [7:0] eng_in;

  // Address cycle byte: two column bytes, then three row bytes
  function automatic logic [7:0] addr_byte(input logic [2:0] idx,
                                           input logic [COL_W-1:0] c,
                                           input logic [ROW_W-1:0] r);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = c[7:0];
      3'h1: b = {3'h0, c[12:8]};
      3'h2: b = r[7:0];
      3'h3: b = r[15:8];
      default: b = {6'h00, r[17:16]};
    endcase
    return b;
  endfunction

  function automatic logic [11:0] blk_of(input logic [ROW_W-1:0] r);
    return r[ROW_W-1:PAGE_W];
  endfunction

  ncmpp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  ncmpp_pin_cycle u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s.eng_start),
    .kind(s.eng_kind),
    .byte_out(s.eng_byte),
    .io_in(io_in),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .byte_in(eng_in),
    .done(eng_done)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      REG_COL: rd_data[COL_W-1:0] = s.col;
      REG_ROW: rd_data[ROW_W-1:0] = s.row;
      REG_DATA: rd_data[7:0] = s.data_rd;
      REG_WPCTL: rd_data[0] = !s.wp_n;
      REG_STAT: begin
        rd_data[STAT_BUSY_BIT] = (s.st != S_IDLE);
        rd_data[STAT_ERR_BIT] = s.err;
        rd_data[STAT_RB_BIT] = ready_busy_output;
        rd_data[STAT_CACHED_BIT] = s.cached;
        rd_data[STAT_MULTI_BIT] = s.multi;
        rd_data[STAT_BYTE_LSB +: 8] = s.stat_byte;
        rd_data[STAT_PAGES_LSB +: 7] = s.pages;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [2:0] op;
    logic [1:0] cfm;
    logic second;
    logic ok;
    logic [11:0] blk;
    logic [PAGE_W-1:0] pg;
    op = wr_data[CTRL_OP_LSB +: 3];
    cfm = wr_data[CTRL_CFM_LSB +: 2];
    second = wr_data[CTRL_SECOND_BIT];
    ok = 1'b0;
    blk = blk_of(s.row);
    pg = s.row[PAGE_W-1:0];
    next_s = s;
    next_s.eng_start = 1'b0;
    if (wr_en) begin
      case (wr_addr)
        REG_COL: next_s.col = wr_data[COL_W-1:0];
        REG_ROW: next_s.row = wr_data[ROW_W-1:0];
        REG_WPCTL: next_s.wp_n = !wr_data[0];
        REG_STAT: begin
          if (wr_data[STAT_ERR_BIT]) begin
            next_s.err = 1'b0;
          end
        end
        REG_DATA: begin
          if (s.st == S_IDLE && (s.ph == P_ADDR1 || s.ph == P_ADDR2)) begin
            next_s.st = S_DATA;
            next_s.eng_start = 1'b1;
            next_s.eng_kind = K_WR;
            next_s.eng_byte = wr_data[7:0];
          end else begin
            next_s.err = 1'b1;
          end
        end
        REG_CTRL: begin
          if (s.st != S_IDLE) begin
            next_s.err = 1'b1;
          end else begin
            case (op)
              OP_SETUP: begin
                if (second) begin
                  ok = s.ph == P_WAIT2 && blk[0] != s.first_blk[0]
                       && blk[HALF_BIT] == s.first_blk[HALF_BIT]
                       && pg == s.first_pg;
                end else begin
                  // A cached run may only move to the next page of its block
                  ok = s.ph == P_NONE && (!s.cached ||
                       (blk == s.seq_blk && pg == s.seq_pg + 6'h1));
                end
                if (ok) begin
                  next_s.cmd = second ? CMD_SETUP2 : CMD_SETUP1;
                  next_s.ph = second ? P_ADDR2 : P_ADDR1;
                  if (!second) begin
                    next_s.first_blk = blk;
                    next_s.first_pg = pg;
                    next_s.seq_blk = blk;
                    next_s.seq_pg = pg;
                    if (!s.cached) begin
                      next_s.multi = 1'b0;
                      next_s.pages = 7'h00;
                    end
                  end
                end
              end
              OP_CONFIRM: begin
                case (cfm)
                  CFM_11: begin
                    ok = s.ph == P_ADDR1 && (!s.cached || s.multi);
                    next_s.cmd = CMD_DIST1;
                  end
                  CFM_15: begin
                    ok = (s.ph == P_ADDR2 ||
                         (s.ph == P_ADDR1 && !s.multi))
                         && s.first_pg != LAST_PAGE;
                    next_s.cmd = CMD_CACHE;
                  end
                  CFM_10: begin
                    ok = s.ph == P_ADDR2 || (s.ph == P_ADDR1 && !s.multi);
                    next_s.cmd = CMD_PROG;
                  end
                  default: ok = 1'b0;
                endcase
                if (ok) begin
                  if (cfm == CFM_11) begin
                    next_s.ph = P_WAIT2;
                    next_s.multi = 1'b1;
                  end else begin
                    next_s.ph = P_NONE;
                    next_s.cached = (cfm == CFM_15);
                    next_s.pages = s.pages + 7'h1;
                  end
                end
              end
              OP_STATUS: begin
                // Only status or reset may break in between the two districts
                ok = s.ph == P_NONE || s.ph == P_WAIT2;
                next_s.cmd = wr_data[CTRL_EXT_BIT] ? CMD_STAT_EXT : CMD_STAT;
              end
              OP_RESET: begin
                ok = 1'b1;
                next_s.cmd = CMD_RESET;
                next_s.ph = P_NONE;
                next_s.cached = 1'b0;
                next_s.multi = 1'b0;
                next_s.pages = 7'h00;
              end
              default: ok = 1'b0;
            endcase
            // Any other order is refused before it reaches the pins
            if (ok) begin
              next_s.st = S_CMD;
              next_s.eng_start = 1'b1;
              next_s.eng_kind = K_CMD;
              next_s.eng_byte = next_s.cmd;
            end else begin
              next_s = s;
              next_s.eng_start = 1'b0;
              next_s.err = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    case (s.st)
      S_IDLE: ;
      S_CMD: begin
        if (eng_done) begin
          case (s.cmd)
            CMD_SETUP1, CMD_SETUP2: begin
              next_s.st = S_ADDR;
              next_s.aidx = 3'h0;
              next_s.eng_start = 1'b1;
              next_s.eng_kind = K_ADDR;
              next_s.eng_byte = addr_byte(3'h0, s.col, s.row);
            end
            CMD_STAT, CMD_STAT_EXT: begin
              next_s.st = S_STAT_RD;
              next_s.eng_start = 1'b1;
              next_s.eng_kind = K_RD;
            end
            default: begin
              // Device raises busy only after the confirm strobe
              next_s.st = S_WB;
              next_s.wb_cnt = 4'(T_WB_CYC - 1);
            end
          endcase
        end
      end
      S_ADDR: begin
        if (eng_done) begin
          if (s.aidx == 3'(ADDR_CYCLES - 1)) begin
            next_s.st = S_IDLE;
          end else begin
            next_s.aidx = s.aidx + 3'h1;
            next_s.eng_start = 1'b1;
            next_s.eng_kind = K_ADDR;
            next_s.eng_byte = addr_byte(s.aidx + 3'h1, s.col, s.row);
          end
        end
      end
      S_DATA: begin
        if (eng_done) begin
          next_s.st = S_IDLE;
        end
      end
      S_WB: begin
        if (s.wb_cnt == 4'h0) begin
          next_s.st = S_WAIT_RB;
        end else begin
          next_s.wb_cnt = s.wb_cnt - 4'h1;
        end
      end
      S_WAIT_RB: begin
        // Cache transfer or final program must finish first
        if (ready_busy_output) begin
          if (s.cmd == CMD_CACHE || s.cmd == CMD_PROG) begin
            next_s.st = S_CMD;
            next_s.cmd = s.multi ? CMD_STAT_EXT : CMD_STAT;
            next_s.eng_start = 1'b1;
            next_s.eng_kind = K_CMD;
            next_s.eng_byte = s.multi ? CMD_STAT_EXT : CMD_STAT;
          end else begin
            next_s.st = S_IDLE;
          end
        end
      end
      S_STAT_RD: begin
        if (eng_done) begin
          // Whole byte kept: page, cache and district results
          next_s.stat_byte = eng_in;
          next_s.data_rd = eng_in;
          next_s.st = S_IDLE;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
    next_s.ce_n = (next_s.st == S_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ce_n <= 1'b1;
      s.wp_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign ce_n = s.ce_n;
  assign wp_n = s.wp_n;

endmodule

// >>> ncmpp_host_assertions.sv
`timescale 1ns/1ps
module ncmpp_host_assertions
  import ncmpp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic io_oe,
  input wire logic [7:0] io_out,
  input wire logic ready_busy_output
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cfm;
    cle && !we_n && (io_out == CMD_CACHE || io_out == CMD_PROG);
  endsequence
  sequence s_stat;
    cle && !we_n && (io_out == CMD_STAT || io_out == CMD_STAT_EXT);
  endsequence
  a_stat_after_cfm: assert property (s_cfm |-> ##[2:600] s_stat)
    else $error("no status read after confirm");
  a_stat_when_ready: assert property (s_stat |-> ready_busy_output)
    else $error("status read while busy");
  a_cfm_latch: assert property (s_cfm |=> we_n && cle && $stable(io_out))
    else $error("confirm not held at strobe rise");
  a_we_pulse: assert property ($fell(we_n) |=> we_n)
    else $error("write strobe too long");
  a_strobe_sel: assert property ((!we_n || !re_n) |-> !ce_n && !(cle && ale))
    else $error("strobe without select");
  a_read_free: assert property (!re_n |-> !io_oe && !cle && !ale)
    else $error("bus driven during read");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write response");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2
    s_axi_rvalid)
    else $error("late read response");
endmodule
bind ncmpp_host ncmpp_host_assertions u_ncmpp_host_assertions (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ce_n(ce_n), .cle(cle), .ale(ale),
  .we_n(we_n), .re_n(re_n), .io_oe(io_oe), .io_out(io_out),
  .ready_busy_output(ready_busy_output));

// >>> ncmpp_dev_model.sv
`timescale 1ns/1ps
module ncmpp_dev_model (
  input wire logic aclk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic [1:0] fail_dist,
  output logic [7:0] io_in,
  output logic ready_busy_output
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] last = 8'h00;
  logic cur = 1'h0;
  logic prev = 1'h0;
  logic [1:0] dfail = 2'h0;
  logic we_q = 1'h1;
  int busy = 0;
  logic rb;
  assign rb = (busy == 0);
  assign ready_busy_output = rb;
  always @(posedge aclk) begin
    we_q <= we_n;
    if (busy > 0)
      busy <= busy - 1;
    if (!we_q && we_n && cle && !ce_n) begin
      cmd <= io_out;
      // Confirm latch sets busy (20 cycles for 10h, 12 for 15h) and moves the last result into prev
      if (io_out == 8'h15 || io_out == 8'h10) begin
        busy <= (io_out == 8'h10) ? 20 : 12;
        prev <= cur;
        cur <= |fail_dist;
        dfail <= fail_dist;
      end
    end
    if (!re_n)
      last <= io_in;
  end
  always_comb begin
    if (!re_n && cmd == 8'h71)
      io_in = {wp_n, rb, rb, 2'h0, dfail, |dfail};
    else if (!re_n)
      io_in = {wp_n, rb, rb, 3'h0, prev, cur};
    else
      io_in = ~last;
  end
endmodule

// >>> tb_ncmpp_host.sv
`timescale 1ns/1ps
module tb_ncmpp_host;
  import ncmpp_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0] fail = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, cle, ale;
  logic we_n, re_n, wp_n, io_oe, rb;
  logic [31:0] rdata, s;
  logic [7:0] io_in, io_out;
  int n_errors = 0;
  int samples_checked = 0;
  always #12.5 aclk = ~aclk;
  ncmpp_host u_ncmpp_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .ready_busy_output(rb));
  ncmpp_dev_model u_ncmpp_dev_model (.aclk(aclk), .ce_n(ce_n), .cle(cle),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
    .fail_dist(fail), .io_in(io_in), .ready_busy_output(rb));
  //////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic guard(ref int n);
    n++;
    if (n > 3000) begin
      n_errors++;
      results();
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      guard(n);
    end while (awvalid || wvalid);
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!arready);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!rvalid);
    d = rdata;
    rready <= 1'h0;
  endtask
  task automatic op(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wr(a, d);
    do begin
      rd(REG_STAT, s);
      guard(n);
    end while (s[STAT_BUSY_BIT] !== 1'h0);
  endtask
  task automatic pg(input logic [31:0] row, su, cf);
    op(REG_ROW, row);
    op(REG_CTRL, su);
    op(REG_DATA, 32'ha5);
    op(REG_CTRL, cf);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(REG_STAT, s);
    chk(s & 32'h7, 32'h4);
    rd(8'h1c, s);
    chk(s, 32'h0);
    fail <= 2'h1;
    pg(32'h80, 32'h1, 32'h12);
    chk(s[15:8], 8'he1);
    op(REG_ROW, 32'hc0);
    op(REG_CTRL, 32'h1);
    chk(s[STAT_ERR_BIT], 1'h1);
    op(REG_STAT, 32'h2);
    fail <= 2'h0;
    pg(32'h81, 32'h1, 32'h22);
    chk(s[15:8], 8'he2);
    chk(s[STAT_ERR_BIT], 1'h0);
    fail <= 2'h2;
    pg(32'h100, 32'h1, 32'h2);
    op(REG_CTRL, 32'h3);
    chk(s[15:8], 8'he2);
    pg(32'h140, 32'h9, 32'h62);
    chk(s[15:8], 8'he5);
    chk(s[STAT_ERR_BIT], 1'h0);
    fail <= 2'h0;
    pg(32'h180, 32'h1, 32'h2);
    pg(32'h20040, 32'h9, 32'h62);
    chk(s[STAT_ERR_BIT], 1'h1);
    op(REG_CTRL, 32'h4);
    op(REG_STAT, 32'h2);
    chk(s[STAT_ERR_BIT], 1'h0);
    pg(32'h3f, 32'h1, 32'h12);
    chk(s[STAT_ERR_BIT], 1'h1);
    op(REG_CTRL, 32'h4);
    op(REG_WPCTL, 32'h1);
    op(REG_CTRL, 32'h3);
    chk(s[15:8], 8'h61);
    results();
  end
endmodule
